// ===== bench/dlog_host_model.sv
`timescale 1ns/10ps

module dlog_host_model (
  // clock and reset
  input  wire logic        clk_i,
  input  wire logic        rstn_i,
  // device side
  input  wire logic        diag_irq_i,
  input  wire logic [31:0] diag_rec_i,
  output logic             rec_read_o,
  // host program
  input  wire logic [7:0]  delay_i,
  input  wire logic        handler_en_i,
  output logic [31:0]      rec_seen_o,
  output logic [7:0]       n_reads_o,
  output logic             stop_o
);
  initial
  begin
    rec_read_o = 1'b0;
    rec_seen_o = 32'h00000000;
    n_reads_o  = 8'h00;
    stop_o     = 1'b0;
  end

  // a slow host leaves the request pending for delay_i + 1 cycles before reading
  always
  begin
    @(negedge clk_i);
    if (rstn_i === 1'b1 && diag_irq_i === 1'b1)
    begin
      repeat (delay_i) @(posedge clk_i);
      @(posedge clk_i);
      rec_seen_o <= diag_rec_i;
      stop_o     <= !handler_en_i;
      n_reads_o  <= n_reads_o + 8'h01;
      rec_read_o <= 1'b1;
      @(posedge clk_i);
      rec_read_o <= 1'b0;
      @(posedge clk_i);
    end
  end
endmodule

// ===== bench/dlog_top_test.sv
`timescale 1ns/10ps
`include "dlog_defs.svh"

module dlog_top_test;
  logic                        clk_i, rstn_i, ev_valid_i, restart_abort_i;
  logic [7:0]                  ev_class_i, ev_num_i, hd;
  logic                        read_record_call_fail_i, write_record_call_fail_i, req_valid_i;
  logic [15:0]                 call_return_value_i, transfer_length_i, call_error_store_o, hist_rd_data_o;
  logic                        param_load_i, param_ok_i, param_irq_en_i, param_default_i, rx_wire_break_i;
  logic                        rec_read_i, diag_irq_o, fault_indicator_o, len_reject_o, hist_rd_valid_o;
  logic                        hist_rd_start_i, hist_rd_next_i, h_en, h_stop;
  logic [31:0]                 diag_rec_o, event_id_o, h_rec;
  logic [7:0]                  h_reads;
  logic [`DLOG_HIST_CNT_W-1:0] hist_count_o;
  int                          n_mismatch, samples_checked;

  dlog_top dut (.clk_i(clk_i), .rstn_i(rstn_i), .ev_valid_i(ev_valid_i), .ev_class_i(ev_class_i),
    .ev_num_i(ev_num_i), .restart_abort_i(restart_abort_i), .read_record_call_fail_i(read_record_call_fail_i),
    .write_record_call_fail_i(write_record_call_fail_i), .call_return_value_i(call_return_value_i),
    .req_valid_i(req_valid_i), .transfer_length_i(transfer_length_i), .param_load_i(param_load_i),
    .param_ok_i(param_ok_i), .param_irq_en_i(param_irq_en_i), .param_default_i(param_default_i),
    .rx_wire_break_i(rx_wire_break_i), .rec_read_i(rec_read_i), .diag_irq_o(diag_irq_o),
    .diag_rec_o(diag_rec_o), .fault_indicator_o(fault_indicator_o), .call_error_store_o(call_error_store_o),
    .len_reject_o(len_reject_o), .event_id_o(event_id_o), .hist_rd_start_i(hist_rd_start_i),
    .hist_rd_next_i(hist_rd_next_i), .hist_rd_data_o(hist_rd_data_o), .hist_rd_valid_o(hist_rd_valid_o),
    .hist_count_o(hist_count_o));

  dlog_host_model host (.clk_i(clk_i), .rstn_i(rstn_i), .diag_irq_i(diag_irq_o), .diag_rec_i(diag_rec_o),
    .rec_read_o(rec_read_i), .delay_i(hd), .handler_en_i(h_en), .rec_seen_o(h_rec), .n_reads_o(h_reads),
    .stop_o(h_stop));

  always #10 clk_i = ~clk_i;

  task automatic chk(input logic [31:0] got, input logic [31:0] exp, input string m);
    samples_checked++;
    if (got !== exp)
    begin
      n_mismatch++;
      $display("CHECK FAILED at %0t: %s got %h exp %h", $time, m, got, exp);
    end
  endtask

  task automatic wt(input int n);
    repeat (n) @(posedge clk_i);
    @(negedge clk_i);
  endtask

  task automatic wirq(input logic exp);
    int i;
    for (i = 0; i < 40 && diag_irq_o !== exp; i++) @(negedge clk_i);
    chk(32'(diag_irq_o), 32'(exp), "irq");
  endtask

  task automatic ev(input logic [7:0] c, input logic [7:0] n);
    @(posedge clk_i);
    ev_valid_i <= 1'b1;
    ev_class_i <= c;
    ev_num_i   <= n;
    @(posedge clk_i);
    ev_valid_i <= 1'b0;
  endtask

  task automatic par(input logic ok, input logic en);
    @(posedge clk_i);
    param_load_i   <= 1'b1;
    param_ok_i     <= ok;
    param_irq_en_i <= en;
    @(posedge clk_i);
    param_load_i   <= 1'b0;
    wt(0);
  endtask

  task automatic rd(input logic first);
    @(posedge clk_i);
    hist_rd_start_i <= first;
    hist_rd_next_i  <= !first;
    @(posedge clk_i);
    hist_rd_start_i <= 1'b0;
    hist_rd_next_i  <= 1'b0;
    @(negedge clk_i);
  endtask

  task automatic t_calls;
    for (int k = 0; k < 3; k++)
    begin
      @(posedge clk_i);
      restart_abort_i          <= (k == 0);
      read_record_call_fail_i  <= (k == 1);
      write_record_call_fail_i <= (k == 2);
      call_return_value_i      <= 16'hA5C0 + 16'(k);
      @(posedge clk_i);
      {restart_abort_i, read_record_call_fail_i, write_record_call_fail_i} <= 3'h0;
      wt(1);
      chk(event_id_o, {16'hF1C8, 8'h1E, 8'h0D + 8'(k)}, "call event id");
      if (k > 0) chk(32'(call_error_store_o), 32'hA5C0 + k, "return value");
      chk(32'(hist_count_o), k + 1, "count");
    end
  endtask

  task automatic t_len;
    logic [15:0] lens [5] = '{16'h0000, 16'h0001, 16'h0400, 16'h0401, 16'hFFFF};
    logic        rej  [5] = '{1'b1, 1'b0, 1'b0, 1'b1, 1'b1};
    for (int k = 0; k < 5; k++)
    begin
      @(posedge clk_i);
      req_valid_i       <= 1'b1;
      transfer_length_i <= lens[k];
      @(posedge clk_i);
      req_valid_i       <= 1'b0;
      wt(0);
      chk(32'(len_reject_o), 32'(rej[k]), "length reject");
      if (rej[k]) chk(event_id_o, 32'hF1C81E41, "length event id");
    end
  endtask

  task automatic t_ovf;
    par(1'b1, 1'b0);
    wt(1);
    chk(32'(hist_count_o), 0, "cleared by load");
    for (int k = 0; k < 18; k++)
    begin
      @(posedge clk_i);
      ev_valid_i <= 1'b1;
      ev_class_i <= 8'h30;
      ev_num_i   <= 8'(k);
    end
    @(posedge clk_i);
    ev_valid_i <= 1'b0;
    // read starts right behind the last write so the newest-first properties fire
    rd(1'b1);
    chk(32'(hist_count_o), `DLOG_HIST_DEPTH, "full count");
    chk(32'(hist_rd_valid_o), 1, "read valid");
    chk(32'(hist_rd_data_o), 32'h3011, "newest");
    for (int k = 1; k < 16; k++)
    begin
      rd(1'b0);
      chk(32'(hist_rd_data_o), 32'h3011 - k, "older entry");
    end
  endtask

  task automatic t_perr;
    hd = 8'h0A;
    par(1'b0, 1'b1);
    chk(32'(diag_irq_o), 1, "param irq");
    chk(diag_rec_o, 32'h00000C83, "param record");
    chk(32'(fault_indicator_o), 1, "indicator");
    wt(1);
    chk(32'(hist_count_o), 1, "first after load");
    chk(event_id_o, 32'hF1C80101, "param event id");
    wt(4);
    chk(32'(diag_irq_o), 1, "still pending");
    wirq(1'b0);
    chk(h_rec, 32'h00000C83, "host record");
  endtask

  task automatic t_brk;
    hd   = 8'h00;
    h_en = 1'b0;
    par(1'b1, 1'b1);
    ev(8'h05, 8'h07);
    wt(2);
    chk(32'(diag_irq_o), 0, "generic no irq");
    @(posedge clk_i);
    rx_wire_break_i <= 1'b1;
    wirq(1'b1);
    chk(diag_rec_o, 32'h00020C25, "break record");
    chk(event_id_o, 32'hF1C80801, "break event id");
    wirq(1'b0);
    chk(32'(h_stop), 1, "host stop");
    @(posedge clk_i);
    rx_wire_break_i <= 1'b0;
    param_default_i <= 1'b1;
    @(posedge clk_i);
    param_default_i <= 1'b0;
    @(posedge clk_i);
    rx_wire_break_i <= 1'b1;
    wt(8);
    chk(32'(diag_irq_o), 0, "defaults off");
    @(posedge clk_i);
    rx_wire_break_i <= 1'b0;
    par(1'b0, 1'b0);
    wt(2);
    chk(32'(diag_irq_o), 0, "disabled param");
    chk(32'(h_reads), 2, "host reads");
  endtask

  task automatic t_pwr;
    @(posedge clk_i);
    rstn_i <= 1'b0;
    wt(2);
    chk(32'(hist_count_o), 0, "power loss clear");
    @(posedge clk_i);
    rstn_i <= 1'b1;
  endtask

  task end_sim;
    if (n_mismatch == 0 && samples_checked > 0)
      $display("[ PASS ]");
    else
      $display("[ FAIL ]");
    $finish;
  endtask

  initial
  begin
    {clk_i, rstn_i, ev_valid_i, restart_abort_i, read_record_call_fail_i, write_record_call_fail_i} = 6'h00;
    {req_valid_i, param_load_i, param_ok_i, param_irq_en_i, param_default_i, rx_wire_break_i} = 6'h00;
    {hist_rd_start_i, hist_rd_next_i, h_en} = 3'h1;
    {ev_class_i, ev_num_i, hd} = 24'h000000;
    {call_return_value_i, transfer_length_i} = 32'h00000000;
    repeat (20) @(posedge clk_i);
    rstn_i <= 1'b1;
    wt(0);
    chk(32'(hist_count_o), 0, "reset count");
    chk(32'(diag_irq_o), 0, "reset irq");
    t_calls();
    t_len();
    t_ovf();
    t_perr();
    t_brk();
    t_pwr();
    end_sim();
  end

  initial
  begin
    repeat (5000) @(posedge clk_i);
    n_mismatch++;
    end_sim();
  end
endmodule

// ===== inc/dlog_defs.svh
`ifndef DLOG_DEFS_SVH
`define DLOG_DEFS_SVH

// history buffer geometry
`define DLOG_HIST_DEPTH   16
`define DLOG_HIST_PTR_W   4
`define DLOG_HIST_CNT_W   5

// event identifier prefix
`define DLOG_ID_PREFIX    16'hF1C8

// backplane communication event codes, class then number
`define DLOG_EV_RESTART   16'h1E0D
`define DLOG_EV_RD_FAIL   16'h1E0E
`define DLOG_EV_WR_FAIL   16'h1E0F
`define DLOG_EV_LEN_BAD   16'h1E41

// log codes for the two interrupting faults
`define DLOG_EV_RXBRK     16'h0801
`define DLOG_EV_PARAM     16'h0101

// transfer length limits in bytes
`define DLOG_LEN_MIN      16'h0001
`define DLOG_LEN_MAX      16'h0400

// diagnostic records, byte 0 in bits 7:0
`define DLOG_REC_RXBRK    32'h00020C25
`define DLOG_REC_PARAM    32'h00000C83
`define DLOG_REC_NONE     32'h00000000

`endif

// ===== inc/dlog_pkg.sv
`include "dlog_defs.svh"

package dlog_pkg;

  typedef enum logic [1:0] {
    DLOG_SRC_NONE  = 2'b00,
    DLOG_SRC_RXBRK = 2'b01,
    DLOG_SRC_PARAM = 2'b10
  } dlog_src_e;

  typedef struct packed {
    logic [`DLOG_HIST_DEPTH-1:0][15:0] mem;
    logic [`DLOG_HIST_PTR_W-1:0]       wr_ptr;
    logic [`DLOG_HIST_CNT_W-1:0]       count;
    logic [`DLOG_HIST_PTR_W-1:0]       rd_idx;
    logic [15:0]                       rd_data;
    logic                              rd_valid;
  } dlog_hist_s;

  typedef struct packed {
    logic        brk_sync1;
    logic        brk_sync2;
    logic        brk_prev;
    logic        irq_en;
    logic        irq_pend;
    dlog_src_e   irq_src;
    logic [31:0] rec;
    logic [15:0] call_err;
    logic [31:0] ev_id;
    logic        len_rej;
    logic        log_v;
    logic [15:0] log_code;
    logic        hist_clr;
  } dlog_top_s;

endpackage

// ===== rtl/dlog_hist.sv
`timescale 1ns/10ps
`include "dlog_defs.svh"

module dlog_hist (
  // clock and reset
  input  wire logic                        clk_i,
  input  wire logic                        rstn_i,
  // write side
  input  wire logic                        clr_i,
  input  wire logic                        wr_i,
  input  wire logic [15:0]                 wr_data_i,
  // read-out side
  input  wire logic                        rd_start_i,
  input  wire logic                        rd_next_i,
  output logic      [15:0]                 rd_data_o,
  output logic                             rd_valid_o,
  output logic      [`DLOG_HIST_CNT_W-1:0] count_o
);

  localparam logic [`DLOG_HIST_CNT_W-1:0] FULL = `DLOG_HIST_CNT_W'(`DLOG_HIST_DEPTH);

  dlog_pkg::dlog_hist_s st_reg;
  dlog_pkg::dlog_hist_s st_next;

  always_comb
  begin
    st_next = st_reg;
    // clear comes first so an event in the same cycle survives the wipe
    if (clr_i)
    begin
      st_next.wr_ptr = '0;
      st_next.count  = '0;
    end
    if (wr_i)
    begin
      // ring overwrite drops the oldest entry once full
      st_next.mem[st_next.wr_ptr] = wr_data_i;
      st_next.wr_ptr = st_next.wr_ptr + 1'b1;
      if (st_next.count != FULL)
        st_next.count = st_next.count + 1'b1;
    end
    if (rd_start_i)
      st_next.rd_idx = '0;
    else if (rd_next_i && (`DLOG_HIST_CNT_W'(st_reg.rd_idx) + 1'b1 < st_next.count))
      st_next.rd_idx = st_reg.rd_idx + 1'b1;
    // offset 0 is always the newest entry
    st_next.rd_data  = st_next.mem[st_next.wr_ptr - 1'b1 - st_next.rd_idx];
    st_next.rd_valid = (`DLOG_HIST_CNT_W'(st_next.rd_idx) < st_next.count);
  end

  always_ff @(posedge clk_i or negedge rstn_i)
  begin
    if (!rstn_i)
      st_reg <= '0;
    else
      st_reg <= st_next;
  end

  assign rd_data_o  = st_reg.rd_data;
  assign rd_valid_o = st_reg.rd_valid;
  assign count_o    = st_reg.count;

  property p_hist_sat;
    @(posedge clk_i) disable iff (!rstn_i)
    (count_o == FULL) && wr_i && !clr_i |=> (count_o == FULL);
  endproperty
  a_hist_sat: assert property (p_hist_sat) else $error("history count left full on write");

  property p_hist_clr;
    @(posedge clk_i) disable iff (!rstn_i)
    clr_i && !wr_i |=> (count_o == '0);
  endproperty
  a_hist_clr: assert property (p_hist_clr) else $error("history not cleared");

  property p_hist_newest;
    @(posedge clk_i) disable iff (!rstn_i)
    wr_i && !clr_i ##1 (rd_start_i && !wr_i && !clr_i) |=> rd_valid_o && (rd_data_o == $past(wr_data_i, 2));
  endproperty
  a_hist_newest: assert property (p_hist_newest) else $error("newest entry not first");

  c_hist_full: cover property (@(posedge clk_i) disable iff (!rstn_i) (count_o == FULL) && wr_i);

endmodule

// ===== rtl/dlog_top.sv
`timescale 1ns/10ps
`include "dlog_defs.svh"
// What this block does
// - restart or reset abandoning a pending host request logs code 1E/0D.
// - failed record read call logs 1E/0E and keeps its return value.
// - failed record write call logs 1E/0F and keeps its return value.
// - transfer length outside 1 to 1024 bytes is rejected and logs 1E/41.
// - one event per cycle enters the history, in order of occurrence; lower-priority ones in that cycle are dropped.
// - hardware, setup, request and transmission faults are all logged.
// - a full history drops its oldest entry to take the new one.
// - history read-out starts at the newest entry, then older ones.
// - history is cleared at power loss and on each new parameter set.
// - event identifier is F1C8 then class byte then number byte.
// - interrupt enable comes from parameters and defaults turn it off.
// - only receive wire break or parameter error raise the interrupt.
// - an interrupting fault places its record where the host reads it.
// - record is four bytes: 25,0C,02,00 for break; 83,0C,00,00 for parameters.

module dlog_top (
  // clock and reset
  input  wire logic                        clk_i,
  input  wire logic                        rstn_i,
  // generic fault events
  input  wire logic                        ev_valid_i,
  input  wire logic [7:0]                  ev_class_i,
  input  wire logic [7:0]                  ev_num_i,
  // backplane request faults
  input  wire logic                        restart_abort_i,
  input  wire logic                        read_record_call_fail_i,
  input  wire logic                        write_record_call_fail_i,
  input  wire logic [15:0]                 call_return_value_i,
  input  wire logic                        req_valid_i,
  input  wire logic [15:0]                 transfer_length_i,
  // parameterization
  input  wire logic                        param_load_i,
  input  wire logic                        param_ok_i,
  input  wire logic                        param_irq_en_i,
  input  wire logic                        param_default_i,
  // receive line pin
  input  wire logic                        rx_wire_break_i,
  // host side of the diagnostic record
  input  wire logic                        rec_read_i,
  output logic                             diag_irq_o,
  output logic      [31:0]                 diag_rec_o,
  output logic                             fault_indicator_o,
  output logic      [15:0]                 call_error_store_o,
  output logic                             len_reject_o,
  output logic      [31:0]                 event_id_o,
  // history read-out
  input  wire logic                        hist_rd_start_i,
  input  wire logic                        hist_rd_next_i,
  output logic      [15:0]                 hist_rd_data_o,
  output logic                             hist_rd_valid_o,
  output logic      [`DLOG_HIST_CNT_W-1:0] hist_count_o
);

  dlog_pkg::dlog_top_s st_reg;
  dlog_pkg::dlog_top_s st_next;

  logic brk_rise;
  logic param_err;
  logic len_bad;
  logic irq_en_eff;

  always_comb
  begin
    st_next = st_reg;
    // the first stage feeds only the second
    st_next.brk_sync1 = rx_wire_break_i;
    st_next.brk_sync2 = st_reg.brk_sync1;
    st_next.brk_prev  = st_reg.brk_sync2;
    brk_rise  = st_reg.brk_sync2 && !st_reg.brk_prev;
    param_err = param_load_i && !param_ok_i;
    len_bad   = req_valid_i &&
                ((transfer_length_i < `DLOG_LEN_MIN) || (transfer_length_i > `DLOG_LEN_MAX));

    // a load takes its own enable at once; defaults lose to a load
    if (param_load_i)
      st_next.irq_en = param_irq_en_i;
    else if (param_default_i)
      st_next.irq_en = 1'b0;
    irq_en_eff = st_next.irq_en;

    st_next.hist_clr = param_load_i;
    st_next.len_rej  = len_bad;

    if (read_record_call_fail_i)
      st_next.call_err = call_return_value_i;
    else if (write_record_call_fail_i)
      st_next.call_err = call_return_value_i;

    // one log entry per cycle; simultaneous lower-priority events are dropped
    st_next.log_v = 1'b1;
    if (restart_abort_i)
      st_next.log_code = `DLOG_EV_RESTART;
    else if (read_record_call_fail_i)
      st_next.log_code = `DLOG_EV_RD_FAIL;
    else if (write_record_call_fail_i)
      st_next.log_code = `DLOG_EV_WR_FAIL;
    else if (len_bad)
      st_next.log_code = `DLOG_EV_LEN_BAD;
    else if (param_err)
      st_next.log_code = `DLOG_EV_PARAM;
    else if (brk_rise)
      st_next.log_code = `DLOG_EV_RXBRK;
    else if (ev_valid_i)
      st_next.log_code = {ev_class_i, ev_num_i};
    else
      st_next.log_v = 1'b0;
    if (st_next.log_v)
      st_next.ev_id = {`DLOG_ID_PREFIX, st_next.log_code};

    // a fresh fault wins over a read in the same cycle
    if (st_reg.irq_pend && rec_read_i)
      st_next.irq_pend = 1'b0;
    // the record being read is consumed, so a fault in that cycle may replace it
    if (irq_en_eff && (!st_reg.irq_pend || rec_read_i) && (param_err || brk_rise))
    begin
      st_next.irq_pend = 1'b1;
      if (param_err)
      begin
        st_next.irq_src = dlog_pkg::DLOG_SRC_PARAM;
        st_next.rec     = `DLOG_REC_PARAM;
      end
      else
      begin
        st_next.irq_src = dlog_pkg::DLOG_SRC_RXBRK;
        st_next.rec     = `DLOG_REC_RXBRK;
      end
    end
  end

  always_ff @(posedge clk_i or negedge rstn_i)
  begin
    if (!rstn_i)
      st_reg <= '0;
    else
      st_reg <= st_next;
  end

  assign diag_irq_o         = st_reg.irq_pend;
  assign fault_indicator_o  = st_reg.irq_pend;
  assign diag_rec_o         = st_reg.rec;
  assign call_error_store_o = st_reg.call_err;
  assign len_reject_o       = st_reg.len_rej;
  assign event_id_o         = st_reg.ev_id;

  // depth is fixed by the defs header, entries are class and number
  dlog_hist u_hist (
    .clk_i      (clk_i),
    .rstn_i     (rstn_i),
    .clr_i      (st_reg.hist_clr),
    .wr_i       (st_reg.log_v),
    .wr_data_i  (st_reg.log_code),
    .rd_start_i (hist_rd_start_i),
    .rd_next_i  (hist_rd_next_i),
    .rd_data_o  (hist_rd_data_o),
    .rd_valid_o (hist_rd_valid_o),
    .count_o    (hist_count_o)
  );

  property p_restart;
    @(posedge clk_i) disable iff (!rstn_i)
    restart_abort_i |=> st_reg.log_v && (event_id_o == {`DLOG_ID_PREFIX, `DLOG_EV_RESTART});
  endproperty
  a_restart: assert property (p_restart) else $error("restart abort not logged");

  property p_rd_fail;
    @(posedge clk_i) disable iff (!rstn_i)
    read_record_call_fail_i && !restart_abort_i |=>
      (call_error_store_o == $past(call_return_value_i)) && (event_id_o[15:0] == `DLOG_EV_RD_FAIL);
  endproperty
  a_rd_fail: assert property (p_rd_fail) else $error("read call failure not kept");

  property p_wr_fail;
    @(posedge clk_i) disable iff (!rstn_i)
    write_record_call_fail_i && !read_record_call_fail_i && !restart_abort_i |=>
      (call_error_store_o == $past(call_return_value_i)) && (event_id_o[15:0] == `DLOG_EV_WR_FAIL);
  endproperty
  a_wr_fail: assert property (p_wr_fail) else $error("write call failure not kept");

  property p_len;
    @(posedge clk_i) disable iff (!rstn_i)
    req_valid_i |=> (len_reject_o == (($past(transfer_length_i) == 16'h0000) ||
                                      ($past(transfer_length_i) > `DLOG_LEN_MAX)));
  endproperty
  a_len: assert property (p_len) else $error("length check wrong");

  property p_order;
    @(posedge clk_i) disable iff (!rstn_i)
    st_reg.log_v && !st_reg.hist_clr ##1 hist_rd_start_i && !st_reg.log_v && !st_reg.hist_clr
      |=> hist_rd_data_o == $past(st_reg.log_code, 2);
  endproperty
  a_order: assert property (p_order) else $error("latest event not at head");

  property p_default;
    @(posedge clk_i) disable iff (!rstn_i)
    param_default_i && !param_load_i ##1 (!param_load_i)[*2] |-> !diag_irq_o || $past(diag_irq_o);
  endproperty
  a_default: assert property (p_default) else $error("defaults left interrupt enabled");

  property p_cause;
    @(posedge clk_i) disable iff (!rstn_i)
    $rose(diag_irq_o) |-> $past(param_load_i && !param_ok_i) || $past(brk_rise);
  endproperty
  a_cause: assert property (p_cause) else $error("interrupt from wrong cause");

  property p_record;
    @(posedge clk_i) disable iff (!rstn_i)
    $rose(diag_irq_o) |-> (diag_rec_o == `DLOG_REC_RXBRK) || (diag_rec_o == `DLOG_REC_PARAM);
  endproperty
  a_record: assert property (p_record) else $error("diagnostic record wrong");

  property p_pending;
    @(posedge clk_i) disable iff (!rstn_i)
    diag_irq_o && !rec_read_i |=> diag_irq_o && $stable(diag_rec_o);
  endproperty
  a_pending: assert property (p_pending) else $error("interrupt dropped before read");

  c_brk_irq: cover property (@(posedge clk_i) disable iff (!rstn_i)
    $rose(diag_irq_o) && (diag_rec_o == `DLOG_REC_RXBRK));
  c_param_irq: cover property (@(posedge clk_i) disable iff (!rstn_i)
    $rose(diag_irq_o) && (diag_rec_o == `DLOG_REC_PARAM));
  c_rec_read: cover property (@(posedge clk_i) disable iff (!rstn_i)
    diag_irq_o && rec_read_i ##1 !diag_irq_o);

endmodule
